// >>> hw/ppp_defines.svh
// constants of the parallel programming port
`ifndef PPP_DEFINES_SVH
`define PPP_DEFINES_SVH
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03
`define PPP_CLK_MHZ 50
`define PPP_BUSY_LO_NS 1000
`define PPP_WR_MIN_US 3700
`define PPP_WR_MAX_US 4500
`define PPP_CE_MIN_US 7500
`define PPP_CE_MAX_US 9000
`define PPP_BUSY_LO_CYC ((`PPP_BUSY_LO_NS * `PPP_CLK_MHZ) / 1000)
`define PPP_WR_CYC (`PPP_WR_MAX_US * `PPP_CLK_MHZ)
`define PPP_CE_CYC (`PPP_CE_MAX_US * `PPP_CLK_MHZ)
`define PPP_FUSE_LO_RST 8'hFF
`define PPP_FUSE_HI_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
`define PPP_SIG0 8'h11
`define PPP_SIG1 8'h22
`define PPP_SIG2 8'h33
`define PPP_CAL_RST 8'hA5
`define PPP_BLANK 8'hFF
`endif

// >>> hw/ppp_pkg.sv
// types of the parallel programming port
package ppp_pkg;
    typedef enum logic [2:0] {
        PPP_OP_NONE = 3'h0,
        PPP_OP_CMD = 3'h1,
        PPP_OP_ADDR = 3'h2,
        PPP_OP_DATA = 3'h3,
        PPP_OP_PAGE = 3'h4,
        PPP_OP_WRITE = 3'h5,
        PPP_OP_READ = 3'h6
    } ppp_op_t;
endpackage

// >>> hw/ppp_if.sv
// pins between programmer and device
`timescale 1ns/1ns
`default_nettype none
interface ppp_if;
    logic load_strobe;
    logic action_select_hi;
    logic action_select_lo;
    logic byte_select_one;
    logic byte_select_two;
    logic page_load_pulse;
    logic write_n;
    logic output_enable_n;
    logic ready_busy_out;
    logic [7:0] data_host_out;
    logic data_host_oe;
    logic [7:0] data_dev_out;
    logic data_dev_oe;
    logic [7:0] data_bus;
    assign data_bus = data_dev_oe ? data_dev_out :
        (data_host_oe ? data_host_out : 8'hFF);
    modport device (
        input load_strobe, action_select_hi, action_select_lo,
        input byte_select_one, byte_select_two, page_load_pulse,
        input write_n, output_enable_n, data_bus,
        output ready_busy_out, data_dev_out, data_dev_oe
    );
    modport host (
        output load_strobe, action_select_hi, action_select_lo,
        output byte_select_one, byte_select_two, page_load_pulse,
        output write_n, output_enable_n, data_host_out, data_host_oe,
        input ready_busy_out, data_bus
    );
endinterface
`default_nettype wire

// >>> hw/ppp_device.sv
// device end of the parallel programming port
// Behaviour
// - action select 00 addr, 01 data, 10 command
// - ready/busy low while write runs
// - programmer ends flash paging with no-op
// - no-op command clears write controls
// - eeprom page load then buffer fills
// - write pulse starts eeprom page program
// - read flash low/high byte by select
// - read eeprom byte with select low
// - fuse write high byte with select one
// - lock write programs zero bits only
// - lock bits cleared only by chip erase or reset
// - fuse/lock read by byte selects
// - signature byte by low address
// - calibration byte with select one high
// - busy low within one microsecond
// - write busy 3.7 to 4.5 ms
// - erase busy 7.5 to 9 ms
`timescale 1ns/1ns
`default_nettype none
`include "ppp_defines.svh"
module ppp_device #(
    parameter int FLASH_AW = 12,
    parameter int EE_AW = 9,
    parameter int PAGE_WBITS = 5,
    parameter int EE_PBITS = 2,
    parameter int WR_CYC = `PPP_WR_CYC,
    parameter int CE_CYC = `PPP_CE_CYC
) (
    input wire logic MCLK,
    input wire logic RST,
    ppp_if.device LINK,
    output logic BUSY
);
    import ppp_pkg::*;
    typedef struct packed {
        logic strobe_q;
        logic page_q;
        logic wr_q;
        logic [7:0] cmd;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] data_lo;
        logic [7:0] data_hi;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [7:0] lock;
        logic write_armed;
        logic busy;
        logic erase_op;
        logic [23:0] count;
        logic [7:0] dout;
    } ppp_dev_state_t;
    ppp_dev_state_t cur_ff, nxt_ff;
    logic [15:0] flash_mem [0:(1<<FLASH_AW)-1];
    logic [7:0] ee_mem [0:(1<<EE_AW)-1];
    logic [15:0] fpage [0:(1<<PAGE_WBITS)-1];
    logic [7:0] epage [0:(1<<EE_PBITS)-1];
    logic [(1<<PAGE_WBITS)-1:0] fpage_vld_ff;
    logic [(1<<EE_PBITS)-1:0] epage_vld_ff;
    logic [15:0] addr_w;
    logic strobe_rise, page_rise, wr_fall, do_prog, do_erase;
    logic [1:0] act;
    assign act = {LINK.action_select_hi, LINK.action_select_lo};
    assign addr_w = {cur_ff.addr_hi, cur_ff.addr_lo};
    assign strobe_rise = LINK.load_strobe & ~cur_ff.strobe_q;
    // no page latch while busy: it would mask the page program
    assign page_rise = LINK.page_load_pulse & ~cur_ff.page_q & ~cur_ff.busy;
    assign wr_fall = ~LINK.write_n & cur_ff.wr_q & ~cur_ff.busy;
    assign do_prog = cur_ff.busy && cur_ff.count == 24'h1 &&
        !cur_ff.erase_op;
    assign do_erase = cur_ff.busy && cur_ff.count == 24'h1 &&
        cur_ff.erase_op;
    function automatic logic [7:0] rd_byte(input ppp_dev_state_t s,
        input logic bs1, input logic bs2, input logic [15:0] fw,
        input logic [7:0] eb);
        logic [7:0] r;
        r = `PPP_BLANK;
        case (s.cmd)
            `PPP_CMD_RFLASH: r = bs1 ? fw[15:8] : fw[7:0];
            `PPP_CMD_REE: r = eb;
            `PPP_CMD_RFUSE: begin
                if (!bs1 && !bs2) r = s.fuse_lo;
                else if (bs1 && bs2) r = s.fuse_hi;
                else if (bs1) r = s.lock;
            end
            `PPP_CMD_RSIG: begin
                if (bs1) r = `PPP_CAL_RST;
                else if (s.addr_lo == 8'h00) r = `PPP_SIG0;
                else if (s.addr_lo == 8'h01) r = `PPP_SIG1;
                else if (s.addr_lo == 8'h02) r = `PPP_SIG2;
            end
            default: r = `PPP_BLANK;
        endcase
        return r;
    endfunction
    // commands that start a self-timed write or erase
    function automatic logic is_wr_cmd(input logic [7:0] c);
        logic w;
        w = 1'b0;
        case (c)
            `PPP_CMD_ERASE, `PPP_CMD_WFUSE, `PPP_CMD_WLOCK,
            `PPP_CMD_WFLASH, `PPP_CMD_WEE: w = 1'b1;
            default: w = 1'b0;
        endcase
        return w;
    endfunction
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.strobe_q = LINK.load_strobe;
        nxt_ff.page_q = LINK.page_load_pulse;
        nxt_ff.wr_q = LINK.write_n;
        if (strobe_rise && !cur_ff.busy) begin
            unique case (act)
                `PPP_ACT_ADDR: begin
                    if (LINK.byte_select_one) nxt_ff.addr_hi = LINK.data_bus;
                    else nxt_ff.addr_lo = LINK.data_bus;
                end
                `PPP_ACT_DATA: begin
                    if (LINK.byte_select_one) nxt_ff.data_hi = LINK.data_bus;
                    else nxt_ff.data_lo = LINK.data_bus;
                end
                `PPP_ACT_CMD: begin
                    nxt_ff.cmd = LINK.data_bus;
                    nxt_ff.write_armed = is_wr_cmd(LINK.data_bus);
                end
                `PPP_ACT_IDLE: ;
            endcase
        end
        if (wr_fall && cur_ff.write_armed) begin
            nxt_ff.busy = 1'b1;
            nxt_ff.erase_op = cur_ff.cmd == `PPP_CMD_ERASE;
            // write fall is seen one edge late, so count one short
            nxt_ff.count = cur_ff.cmd == `PPP_CMD_ERASE ?
                24'(CE_CYC - 1) : 24'(WR_CYC - 1);
            if (cur_ff.cmd == `PPP_CMD_WFUSE && !LINK.byte_select_two) begin
                if (LINK.byte_select_one)
                    nxt_ff.fuse_hi = cur_ff.data_lo;
                else
                    nxt_ff.fuse_lo = cur_ff.data_lo;
            end
            if (cur_ff.cmd == `PPP_CMD_WLOCK)
                nxt_ff.lock = cur_ff.lock & cur_ff.data_lo;
        end else if (cur_ff.busy) begin
            nxt_ff.count = cur_ff.count - 24'h1;
            if (cur_ff.count == 24'h1) begin
                nxt_ff.busy = 1'b0;
                if (cur_ff.erase_op) nxt_ff.lock = `PPP_LOCK_RST;
            end
        end
        nxt_ff.dout = rd_byte(cur_ff, LINK.byte_select_one,
            LINK.byte_select_two, flash_mem[addr_w[FLASH_AW-1:0]],
            ee_mem[addr_w[EE_AW-1:0]]);
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cur_ff <= '0;
            cur_ff.fuse_lo <= `PPP_FUSE_LO_RST;
            cur_ff.fuse_hi <= `PPP_FUSE_HI_RST;
            cur_ff.lock <= `PPP_LOCK_RST;
            cur_ff.strobe_q <= 1'b1;
            cur_ff.wr_q <= 1'b1;
            cur_ff.dout <= `PPP_BLANK;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    // page buffers and array updates
    always_ff @(posedge MCLK) begin
        if (RST) begin
            fpage_vld_ff <= '0;
            epage_vld_ff <= '0;
        end else if (page_rise) begin
            if (cur_ff.cmd == `PPP_CMD_WEE) begin
                epage[cur_ff.addr_lo[EE_PBITS-1:0]] <= cur_ff.data_lo;
                epage_vld_ff[cur_ff.addr_lo[EE_PBITS-1:0]] <= 1'b1;
            end else begin
                fpage[cur_ff.addr_lo[PAGE_WBITS-1:0]] <=
                    {cur_ff.data_hi, cur_ff.data_lo};
                fpage_vld_ff[cur_ff.addr_lo[PAGE_WBITS-1:0]] <= 1'b1;
            end
        end else if (do_prog) begin
            for (int i = 0; i < (1 << PAGE_WBITS); i++) begin
                if (fpage_vld_ff[i] && cur_ff.cmd == `PPP_CMD_WFLASH)
                    flash_mem[{addr_w[FLASH_AW-1:PAGE_WBITS],
                        PAGE_WBITS'(i)}] <= fpage[i];
            end
            for (int j = 0; j < (1 << EE_PBITS); j++) begin
                if (epage_vld_ff[j] && cur_ff.cmd == `PPP_CMD_WEE)
                    ee_mem[{addr_w[EE_AW-1:EE_PBITS], EE_PBITS'(j)}] <=
                        epage[j];
            end
            fpage_vld_ff <= '0;
            epage_vld_ff <= '0;
        end else if (do_erase) begin
            for (int k = 0; k < (1 << FLASH_AW); k++)
                flash_mem[k] <= 16'hFFFF;
            for (int m = 0; m < (1 << EE_AW); m++)
                ee_mem[m] <= `PPP_BLANK;
        end
    end
    assign LINK.ready_busy_out = ~cur_ff.busy;
    assign LINK.data_dev_out = cur_ff.dout;
    assign LINK.data_dev_oe = ~LINK.output_enable_n;
    assign BUSY = cur_ff.busy;
endmodule
`default_nettype wire

// >>> hw/ppp_host.sv
// programmer end of the parallel programming port
`timescale 1ns/1ns
`default_nettype none
`include "ppp_defines.svh"
module ppp_host #(
    parameter int PULSE_CYC = 8
) (
    input wire logic MCLK,
    input wire logic RST,
    ppp_if.host LINK,
    input wire ppp_pkg::ppp_op_t OP,
    input wire logic OP_VALID,
    input wire logic [7:0] OP_BYTE,
    input wire logic OP_BS1,
    input wire logic OP_BS2,
    output logic OP_READY,
    output logic [7:0] RD_DATA,
    output logic RD_VALID
);
    import ppp_pkg::*;
    typedef enum logic [1:0] {
        PPP_H_IDLE = 2'h0,
        PPP_H_HIGH = 2'h1,
        PPP_H_LOW = 2'h2,
        PPP_H_WAIT = 2'h3
    } ppp_hst_t;
    typedef struct packed {
        ppp_hst_t st;
        ppp_op_t op;
        logic [7:0] cnt;
        logic [1:0] act;
        logic bs1;
        logic bs2;
        logic [7:0] dat;
        logic [7:0] rd;
        logic rd_vld;
    } ppp_host_state_t;
    ppp_host_state_t cur_ff, nxt_ff;
    logic is_write, is_read;
    assign is_write = cur_ff.op == PPP_OP_WRITE;
    assign is_read = cur_ff.op == PPP_OP_READ;
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rd_vld = 1'b0;
        unique case (cur_ff.st)
            PPP_H_IDLE: begin
                if (OP_VALID && LINK.ready_busy_out) begin
                    nxt_ff.op = OP;
                    nxt_ff.dat = OP_BYTE;
                    nxt_ff.bs1 = OP_BS1;
                    nxt_ff.bs2 = OP_BS2;
                    nxt_ff.cnt = 8'(PULSE_CYC);
                    unique case (OP)
                        PPP_OP_CMD: nxt_ff.act = `PPP_ACT_CMD;
                        PPP_OP_ADDR: nxt_ff.act = `PPP_ACT_ADDR;
                        PPP_OP_DATA: nxt_ff.act = `PPP_ACT_DATA;
                        default: nxt_ff.act = `PPP_ACT_IDLE;
                    endcase
                    nxt_ff.st = (OP == PPP_OP_NONE) ? PPP_H_IDLE : PPP_H_HIGH;
                end
            end
            PPP_H_HIGH: begin
                nxt_ff.cnt = cur_ff.cnt - 8'h1;
                if (cur_ff.cnt == 8'h1) begin
                    nxt_ff.cnt = 8'(PULSE_CYC);
                    nxt_ff.st = PPP_H_LOW;
                    if (is_read) begin
                        nxt_ff.rd = LINK.data_bus;
                        nxt_ff.rd_vld = 1'b1;
                    end
                end
            end
            PPP_H_LOW: begin
                nxt_ff.cnt = cur_ff.cnt - 8'h1;
                if (cur_ff.cnt == 8'h1) begin
                    nxt_ff.st = is_write ? PPP_H_WAIT : PPP_H_IDLE;
                    if (is_write) nxt_ff.bs1 = 1'b0;
                end
            end
            PPP_H_WAIT: begin
                if (LINK.ready_busy_out) nxt_ff.st = PPP_H_IDLE;
            end
        endcase
    end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            cur_ff <= '0;
            cur_ff.act <= `PPP_ACT_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end
    // strobes: load/page active high, write and output enable active low
    always_comb begin
        LINK.action_select_hi = cur_ff.act[1];
        LINK.action_select_lo = cur_ff.act[0];
        LINK.byte_select_one = cur_ff.bs1;
        LINK.byte_select_two = cur_ff.bs2;
        LINK.data_host_out = cur_ff.dat;
        LINK.data_host_oe = !is_read || cur_ff.st == PPP_H_IDLE;
        LINK.load_strobe = cur_ff.st == PPP_H_HIGH &&
            (cur_ff.op == PPP_OP_CMD || cur_ff.op == PPP_OP_ADDR ||
            cur_ff.op == PPP_OP_DATA);
        LINK.page_load_pulse = cur_ff.st == PPP_H_HIGH &&
            cur_ff.op == PPP_OP_PAGE;
        LINK.write_n = !(cur_ff.st == PPP_H_HIGH && is_write);
        LINK.output_enable_n = !(cur_ff.st != PPP_H_IDLE && is_read);
    end
    assign OP_READY = cur_ff.st == PPP_H_IDLE && LINK.ready_busy_out;
    assign RD_DATA = cur_ff.rd;
    assign RD_VALID = cur_ff.rd_vld;
endmodule
`default_nettype wire

// >>> verif/ppp_monitor.sv
// pin-level checks of the programming port
`timescale 1ns/1ns
`default_nettype none
`include "ppp_defines.svh"
module ppp_monitor #(
    parameter int WR_CYC = 20,
    parameter int CE_CYC = 40
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic load_strobe,
    input wire logic action_select_hi,
    input wire logic action_select_lo,
    input wire logic byte_select_one,
    input wire logic write_n,
    input wire logic output_enable_n,
    input wire logic ready_busy_out,
    input wire logic data_dev_oe,
    input wire logic [7:0] data_bus
);
    typedef struct packed {
        logic ls;
        logic [7:0] cmd;
        logic [7:0] addr;
        logic [19:0] cnt;
    } ppp_mon_t;
    ppp_mon_t mon_ff;
    ppp_mon_t nxt_mon;
    logic [7:0] sig_exp;
    // shadow of loaded command, low address and busy length
    always_comb begin
        nxt_mon = mon_ff;
        nxt_mon.ls = load_strobe;
        nxt_mon.cnt = ready_busy_out ? 20'h00000 : mon_ff.cnt + 20'h00001;
        if (load_strobe && !mon_ff.ls) begin
            if ({action_select_hi, action_select_lo} == `PPP_ACT_CMD)
                nxt_mon.cmd = data_bus;
            if ({action_select_hi, action_select_lo} == `PPP_ACT_ADDR &&
                    !byte_select_one)
                nxt_mon.addr = data_bus;
        end
        sig_exp = (mon_ff.addr == 8'h00) ? `PPP_SIG0 :
            ((mon_ff.addr == 8'h01) ? `PPP_SIG1 : `PPP_SIG2);
    end
    always_ff @(posedge MCLK) begin
        if (RST)
            mon_ff <= '0;
        else
            mon_ff <= nxt_mon;
    end
    default clocking mon_cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_wr_start;
        $fell(write_n) && ready_busy_out && mon_ff.cmd[7:4] != 4'h0;
    endsequence
    sequence s_done;
        $rose(ready_busy_out);
    endsequence
    sequence s_settled;
        !output_enable_n && !$past(output_enable_n) &&
            $stable(byte_select_one);
    endsequence
    property p_busy_fall;
        s_wr_start |-> ##[1:50] !ready_busy_out;
    endproperty
    property p_wr_len;
        s_done ##0 (mon_ff.cmd != `PPP_CMD_ERASE) |->
            mon_ff.cnt >= WR_CYC * 37 / 45 && mon_ff.cnt <= WR_CYC - 1;
    endproperty
    property p_ce_len;
        s_done ##0 (mon_ff.cmd == `PPP_CMD_ERASE) |->
            mon_ff.cnt >= CE_CYC * 75 / 90 && mon_ff.cnt <= CE_CYC - 1;
    endproperty
    property p_nop_idle;
        $fell(write_n) && mon_ff.cmd == `PPP_CMD_NOP |=>
            ready_busy_out [*4];
    endproperty
    property p_quiet;
        !ready_busy_out |-> !load_strobe;
    endproperty
    property p_bus_owner;
        s_settled ##1 s_settled |-> data_dev_oe && $stable(data_bus);
    endproperty
    property p_hold;
        load_strobe && $past(load_strobe) |->
            $stable({action_select_hi, action_select_lo, data_bus});
    endproperty
    property p_sig_read;
        s_settled ##0 (mon_ff.cmd == `PPP_CMD_RSIG && !byte_select_one &&
            mon_ff.addr <= 8'h02) |-> data_bus == sig_exp;
    endproperty
    property p_cal_read;
        s_settled ##0 (mon_ff.cmd == `PPP_CMD_RSIG && byte_select_one) |->
            data_bus == `PPP_CAL_RST;
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("busy late after write pulse");
    a_wr_len: assert property (p_wr_len)
        else $error("write busy length wrong");
    a_ce_len: assert property (p_ce_len)
        else $error("erase busy length wrong");
    a_nop_idle: assert property (p_nop_idle)
        else $error("write after no-op went busy");
    a_quiet: assert property (p_quiet)
        else $error("load while busy");
    a_bus_owner: assert property (p_bus_owner)
        else $error("device read byte moved while selects held");
    a_hold: assert property (p_hold)
        else $error("load inputs moved under strobe");
    a_sig_read: assert property (p_sig_read)
        else $error("wrong identification byte");
    a_cal_read: assert property (p_cal_read)
        else $error("wrong calibration byte");
endmodule
`default_nettype wire

// >>> verif/tb_parallel_program_port.sv
// bench: programmer and device ends joined over the pin interface
`timescale 1ns/1ns
`default_nettype none
`include "ppp_defines.svh"
module tb_parallel_program_port;
    import ppp_pkg::*;
    localparam int WR_CYC = 20;
    localparam int CE_CYC = 40;
    localparam int WR_LO = WR_CYC * 37 / 45;
    localparam int CE_LO = CE_CYC * 75 / 90;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    ppp_op_t op = PPP_OP_NONE;
    logic op_valid = 1'b0;
    logic [7:0] op_byte = 8'h00;
    logic op_bs1 = 1'b0;
    logic op_bs2 = 1'b0;
    logic op_ready;
    logic [7:0] rd_data;
    logic rd_valid;
    logic busy;
    logic [7:0] sig_tab [3] = '{`PPP_SIG0, `PPP_SIG1, `PPP_SIG2};
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int busy_cyc = 0;
    ppp_if link();
    ppp_device #(.WR_CYC(WR_CYC), .CE_CYC(CE_CYC)) ppp_device_inst (
        .MCLK(mclk), .RST(rst), .LINK(link.device), .BUSY(busy));
    ppp_host ppp_host_inst (
        .MCLK(mclk), .RST(rst), .LINK(link.host), .OP(op),
        .OP_VALID(op_valid), .OP_BYTE(op_byte), .OP_BS1(op_bs1),
        .OP_BS2(op_bs2), .OP_READY(op_ready), .RD_DATA(rd_data),
        .RD_VALID(rd_valid));
    ppp_monitor #(.WR_CYC(WR_CYC), .CE_CYC(CE_CYC)) ppp_monitor_inst (
        .MCLK(mclk), .RST(rst), .load_strobe(link.load_strobe),
        .action_select_hi(link.action_select_hi),
        .action_select_lo(link.action_select_lo),
        .byte_select_one(link.byte_select_one), .write_n(link.write_n),
        .output_enable_n(link.output_enable_n),
        .ready_busy_out(link.ready_busy_out),
        .data_dev_oe(link.data_dev_oe), .data_bus(link.data_bus));
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (busy === 1'b1)
            busy_cyc <= busy_cyc + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input ppp_op_t o, input logic [7:0] b,
            input logic s1, input logic s2);
        @(posedge mclk);
        op <= o;
        op_byte <= b;
        op_bs1 <= s1;
        op_bs2 <= s2;
        op_valid <= 1'b1;
        @(negedge mclk);
        while (op_ready !== 1'b1)
            @(negedge mclk);
        @(posedge mclk);
        op_valid <= 1'b0;
    endtask
    task automatic rd(input string what, input logic s1, input logic s2,
            input logic [7:0] exp);
        put(PPP_OP_READ, 8'h00, s1, s2);
        @(negedge mclk);
        while (rd_valid !== 1'b1)
            @(negedge mclk);
        chk(what, exp, rd_data);
    endtask
    // write pulse, wait for ready, judge busy length
    task automatic wr(input logic s1, input int lo, input int hi);
        int b0;
        b0 = busy_cyc;
        put(PPP_OP_WRITE, 8'h00, s1, 1'b0);
        @(negedge mclk);
        while (op_ready !== 1'b1)
            @(negedge mclk);
        chk("busy span", 8'h01,
            {7'h00, busy_cyc - b0 >= lo && busy_cyc - b0 <= hi});
    endtask
    task automatic t_sig();
        put(PPP_OP_CMD, `PPP_CMD_RSIG, 1'b0, 1'b0);
        for (int a = 0; a < 3; a++) begin
            put(PPP_OP_ADDR, 8'(a), 1'b0, 1'b0);
            rd("signature", 1'b0, 1'b0, sig_tab[a]);
            rd("calibration", 1'b1, 1'b0, `PPP_CAL_RST);
        end
        $display("signature test done");
    endtask
    task automatic t_fuse();
        put(PPP_OP_CMD, `PPP_CMD_RFUSE, 1'b0, 1'b0);
        rd("fuse low", 1'b0, 1'b0, `PPP_FUSE_LO_RST);
        rd("fuse high", 1'b1, 1'b1, `PPP_FUSE_HI_RST);
        rd("lock", 1'b1, 1'b0, `PPP_LOCK_RST);
        put(PPP_OP_CMD, `PPP_CMD_WFUSE, 1'b0, 1'b0);
        put(PPP_OP_DATA, 8'h5A, 1'b0, 1'b0);
        wr(1'b0, WR_LO, WR_CYC - 1);
        put(PPP_OP_DATA, 8'hC3, 1'b0, 1'b0);
        wr(1'b1, WR_LO, WR_CYC - 1);
        put(PPP_OP_CMD, `PPP_CMD_RFUSE, 1'b0, 1'b0);
        rd("fuse low", 1'b0, 1'b0, 8'h5A);
        rd("fuse high", 1'b1, 1'b1, 8'hC3);
        $display("fuse test done");
    endtask
    task automatic t_lock();
        put(PPP_OP_CMD, `PPP_CMD_WLOCK, 1'b0, 1'b0);
        put(PPP_OP_DATA, 8'hF0, 1'b0, 1'b0);
        wr(1'b0, WR_LO, WR_CYC - 1);
        put(PPP_OP_DATA, 8'hFF, 1'b0, 1'b0);
        wr(1'b0, WR_LO, WR_CYC - 1);
        put(PPP_OP_CMD, `PPP_CMD_RFUSE, 1'b0, 1'b0);
        rd("lock", 1'b1, 1'b0, 8'hF0);
        put(PPP_OP_CMD, `PPP_CMD_ERASE, 1'b0, 1'b0);
        wr(1'b0, CE_LO, CE_CYC - 1);
        put(PPP_OP_CMD, `PPP_CMD_RFUSE, 1'b0, 1'b0);
        rd("lock", 1'b1, 1'b0, `PPP_LOCK_RST);
        rd("fuse low", 1'b0, 1'b0, 8'h5A);
        $display("lock test done");
    endtask
    task automatic t_flash();
        put(PPP_OP_CMD, `PPP_CMD_WFLASH, 1'b0, 1'b0);
        put(PPP_OP_ADDR, 8'h00, 1'b1, 1'b0);
        put(PPP_OP_ADDR, 8'h05, 1'b0, 1'b0);
        put(PPP_OP_DATA, 8'h34, 1'b0, 1'b0);
        put(PPP_OP_DATA, 8'h12, 1'b1, 1'b0);
        put(PPP_OP_PAGE, 8'h00, 1'b1, 1'b0);
        wr(1'b0, WR_LO, WR_CYC - 1);
        put(PPP_OP_CMD, `PPP_CMD_NOP, 1'b0, 1'b0);
        wr(1'b0, 0, 0);
        put(PPP_OP_CMD, `PPP_CMD_RFLASH, 1'b0, 1'b0);
        put(PPP_OP_ADDR, 8'h00, 1'b1, 1'b0);
        put(PPP_OP_ADDR, 8'h05, 1'b0, 1'b0);
        rd("flash low", 1'b0, 1'b0, 8'h34);
        rd("flash high", 1'b1, 1'b0, 8'h12);
        $display("flash test done");
    endtask
    task automatic t_ee();
        put(PPP_OP_CMD, `PPP_CMD_WEE, 1'b0, 1'b0);
        put(PPP_OP_ADDR, 8'h00, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            put(PPP_OP_ADDR, 8'(i), 1'b0, 1'b0);
            put(PPP_OP_DATA, 8'hA0 + 8'(i), 1'b0, 1'b0);
            put(PPP_OP_PAGE, 8'h00, 1'b0, 1'b0);
        end
        wr(1'b0, WR_LO, WR_CYC - 1);
        put(PPP_OP_CMD, `PPP_CMD_REE, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            put(PPP_OP_ADDR, 8'(i), 1'b0, 1'b0);
            rd("eeprom", 1'b0, 1'b0, 8'hA0 + 8'(i));
        end
        $display("eeprom test done");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_sig();
        t_fuse();
        t_lock();
        t_flash();
        t_ee();
        summarize();
    end
endmodule
`default_nettype wire
